/* File: core/i2c_slave_regs.svh */
`ifndef I2C_SLAVE_REGS_SVH
`define I2C_SLAVE_REGS_SVH
// Summary of operation
// - Address match wakes the device when wake-up enable set; software clears it.
// - Transmitter samples acknowledge on ninth clock; low clears, high sets flag.
// - Slave transmitter continues while acknowledged, releases SDA on no acknowledge.
// - After START shift seven address bits MSB first; match sets flag, interrupt.
// - Eighth address bit stored as master read flag, one meaning master reads.
// - On address match drive SDA low during ninth address bit period.
// - START is SDA falling while SCL high; it sets bus busy.
// - Only the master makes START; slave only detects it.
// - One interrupt from address match, byte done or bus time-out.
// - After match hold SCL low until data written (transmit) or read (receive).
// - Data bytes are eight bits, MSB first, only after address acknowledged.
// - Receiver drives the transmit acknowledge value on ninth clock.
// - Time-out counter starts on START plus match, restarts on SCL fall, stops on STOP.
// - Time-out when time since last SCL fall exceeds selected period.
// - On overflow stop counter, clear enable, set flag, raise interrupt.
// - Time-out resets engine and bus status register; other registers unchanged.
// - Period is (select plus one) times 32 sub clocks; counter runs at sub/32.
// - Own address in bits 7 to 1; bit 0 ignored by the match.
// - Byte done flag rises with interrupt after each byte, low while shifting; the code leaves it low after the address byte.
// - Bus busy clears when STOP is detected.
`define OFS_MODE_CTRL    8'h00
`define OFS_BUS_STATUS   8'h04
`define OFS_OWN_ADDR     8'h08
`define OFS_SERIAL_DATA  8'h0C
`define OFS_TIMEOUT_CTRL 8'h10
`define OFS_IRQ_CTRL     8'h14
`define MODE_CTRL_RST    8'hE0
`define MODE_CTRL_MASK   8'hEF
`define BUS_STATUS_RST   8'h81
`define MODE_I2C_SLAVE   3'h6
`define MODE_FIELD_HI    7
`define MODE_FIELD_LO    5
`define MODE_EN_BIT      1
`define IRQ_EN_BIT       0
`define BIT_ADDR_LAST    4'h7
`define BIT_ACK_DRIVE    4'h8
`define BIT_ACK_DONE     4'h9
`define SUB_DIV_LAST     5'h1F
`endif

/* File: core/i2c_slave_pkg.sv */
package i2c_slave_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ADDR = 3'h1,
    ST_ACK  = 3'h3,
    ST_HOLD = 3'h2,
    ST_DATA = 3'h6,
    ST_WAIT = 3'h7
  } eng_state_e;

  typedef struct packed {
    logic byte_done_flag;
    logic address_match_flag;
    logic bus_busy_flag;
    logic transmit_direction_select;
    logic tx_ack_value;
    logic master_read_flag;
    logic addr_match_wakeup_en;
    logic rx_ack_flag;
  } bus_status_s;

  typedef struct packed {
    logic       timeout_enable;
    logic       timeout_flag;
    logic [5:0] timeout_period_select;
  } timeout_ctrl_s;

  typedef struct packed {
    logic [4:0] pre;
    logic [5:0] per;
    logic       expire;
  } timeout_cnt_s;

  typedef struct packed {
    logic [7:0]    mode_ctrl;
    bus_status_s   status;
    logic [7:0]    own_addr;
    logic [7:0]    data;
    timeout_ctrl_s toc;
    logic          irq_en;
    logic [7:0]    shift;
    logic [3:0]    bitcnt;
    eng_state_e    st;
    logic          in_addr;
    logic          to_run;
    logic          scl_d;
    logic          sda_d;
    logic          sub_d;
    logic          sda_oe_n;
    logic          scl_oe_n;
    logic          irq;
    logic          wake;
    logic          ph_wr;
    logic [7:0]    ph_addr;
    logic [31:0]   rdata;
    logic          rdy;
    logic          lo;
  } core_s;
endpackage

/* File: core/i2c_sync2.sv */
`timescale 1ns/100ps
module i2c_sync2 #(
  parameter int W = 3
) (
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_s;

  sync_s r_reg;
  sync_s r_next;

  // First stage feeds only the second stage
  always_comb begin
    r_next    = r_reg;
    r_next.s1 = d;
    r_next.s2 = r_reg.s1;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r_reg <= '1;
    end else begin
      r_reg <= r_next;
    end
  end

  assign q = r_reg.s2;
endmodule // i2c_sync2

/* File: core/i2c_bus_timeout.sv */
`timescale 1ns/100ps
`include "i2c_slave_regs.svh"
module i2c_bus_timeout (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       sub_tick,
  input  wire logic       run,
  input  wire logic       restart,
  input  wire logic [5:0] sel,
  output logic            expire
);
  i2c_slave_pkg::timeout_cnt_s r_reg;
  i2c_slave_pkg::timeout_cnt_s r_next;

  always_comb begin
    r_next        = r_reg;
    r_next.expire = 1'b0;
    if (!run || restart) begin
      r_next.pre = '0;
      r_next.per = '0;
    end else if (sub_tick) begin
      if (r_reg.pre == `SUB_DIV_LAST) begin
        r_next.pre = '0;
        if (r_reg.per == sel) begin
          r_next.per    = '0;
          r_next.expire = 1'b1;
        end else begin
          r_next.per = r_reg.per + 6'h01;
        end
      end else begin
        r_next.pre = r_reg.pre + 5'h01;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign expire = r_reg.expire;
endmodule // i2c_bus_timeout

/* File: core/i2c_slave_with_timeout.sv */
// The AHB-Lite slave port and the placing of the registers were decided locally.
`timescale 1ns/100ps
`include "i2c_slave_regs.svh"
module i2c_slave_with_timeout (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        scl_i,
  output logic             scl_o,
  output logic             scl_oe_n,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe_n,
  input  wire logic        sub_clk,
  output logic             irq,
  output logic             wake
);
  localparam i2c_slave_pkg::core_s CORE_RST = '{
    mode_ctrl: `MODE_CTRL_RST,
    status:    `BUS_STATUS_RST,
    st:        i2c_slave_pkg::ST_IDLE,
    scl_d:     1'b1,
    sda_d:     1'b1,
    sub_d:     1'b1,
    sda_oe_n:  1'b1,
    scl_oe_n:  1'b1,
    rdy:       1'b1,
    default:   '0
  };

  i2c_slave_pkg::core_s r_reg;
  i2c_slave_pkg::core_s r_next;

  logic [2:0] pins_s;
  logic       scl_s;
  logic       sda_s;
  logic       sub_s;
  logic       expire;
  logic       scl_fall;

  i2c_sync2 #(
    .W (3)
  ) u_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .d       ({sub_clk, sda_i, scl_i}),
    .q       (pins_s)
  );

  assign sub_s    = pins_s[2];
  assign sda_s    = pins_s[1];
  assign scl_s    = pins_s[0];
  assign scl_fall = r_reg.scl_d & ~scl_s;

  i2c_bus_timeout u_timeout (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .sub_tick (sub_s & ~r_reg.sub_d),
    .run      (r_reg.to_run & r_reg.toc.timeout_enable),
    .restart  (scl_fall),
    .sel      (r_reg.toc.timeout_period_select),
    .expire   (expire)
  );

  always_comb begin
    logic        active;
    logic        scl_rise;
    logic        start;
    logic        stop;
    logic        take;
    logic        data_rd;
    logic        data_wr;
    logic        event_hit;
    logic        en_rise;
    logic [7:0]  rd_val;
    logic [7:0]  shin;
    i2c_slave_pkg::bus_status_s wr_status;
    active    = 1'b0;
    scl_rise  = 1'b0;
    start     = 1'b0;
    stop      = 1'b0;
    take      = 1'b0;
    data_rd   = 1'b0;
    data_wr   = 1'b0;
    event_hit = 1'b0;
    en_rise   = 1'b0;
    rd_val    = 8'h00;
    shin      = {r_reg.shift[6:0], sda_s};
    wr_status = i2c_slave_pkg::bus_status_s'(hwdata[7:0]);

    r_next       = r_reg;
    r_next.irq   = 1'b0;
    r_next.wake  = 1'b0;
    r_next.scl_d = scl_s;
    r_next.sda_d = sda_s;
    r_next.sub_d = sub_s;

    active   = (r_reg.mode_ctrl[`MODE_FIELD_HI:`MODE_FIELD_LO]
               == `MODE_I2C_SLAVE) & r_reg.mode_ctrl[`MODE_EN_BIT];
    scl_rise = ~r_reg.scl_d & scl_s;
    // START is SDA fall, SCL high
    start    = r_reg.scl_d & scl_s & r_reg.sda_d & ~sda_s;
    stop     = r_reg.scl_d & scl_s & ~r_reg.sda_d & sda_s;

    // Bus address phase; read data is prepared here for the data phase
    take           = hsel & htrans[1] & hready;
    r_next.ph_wr   = take & hwrite;
    r_next.ph_addr = haddr[7:0];
    unique case (haddr[7:0])
      `OFS_MODE_CTRL:    rd_val = r_reg.mode_ctrl;
      `OFS_BUS_STATUS:   rd_val = r_reg.status;
      `OFS_OWN_ADDR:     rd_val = r_reg.own_addr;
      `OFS_SERIAL_DATA:  rd_val = r_reg.data;
      `OFS_TIMEOUT_CTRL: rd_val = r_reg.toc;
      `OFS_IRQ_CTRL:     rd_val = {7'h00, r_reg.irq_en};
      default:           rd_val = 8'h00;
    endcase
    if (take) begin
      r_next.rdata = {24'h000000, (hwrite ? 8'h00 : rd_val)};
    end
    data_rd = take & ~hwrite & (haddr[7:0] == `OFS_SERIAL_DATA);

    // Data phase writes; hardware updates below override them
    if (r_reg.ph_wr) begin
      unique case (r_reg.ph_addr)
        `OFS_MODE_CTRL: begin
          r_next.mode_ctrl = hwdata[7:0] & `MODE_CTRL_MASK;
          en_rise = hwdata[`MODE_EN_BIT] & ~r_reg.mode_ctrl[`MODE_EN_BIT];
        end
        `OFS_BUS_STATUS: begin
          r_next.status.transmit_direction_select =
            wr_status.transmit_direction_select;
          r_next.status.tx_ack_value = wr_status.tx_ack_value;
          r_next.status.addr_match_wakeup_en =
            wr_status.addr_match_wakeup_en;
        end
        `OFS_OWN_ADDR: r_next.own_addr = hwdata[7:0];
        `OFS_SERIAL_DATA: begin
          r_next.data = hwdata[7:0];
          data_wr     = 1'b1;
        end
        `OFS_TIMEOUT_CTRL: begin
          r_next.toc = hwdata[7:0];
        end
        `OFS_IRQ_CTRL: r_next.irq_en = hwdata[`IRQ_EN_BIT];
        default: ;
      endcase
    end

    // Enabling again returns the bus flags to defaults, keeps controls
    if (en_rise) begin
      r_next.status.byte_done_flag     = 1'b1;
      r_next.status.address_match_flag = 1'b0;
      r_next.status.bus_busy_flag      = 1'b0;
      r_next.status.master_read_flag   = 1'b0;
      r_next.status.rx_ack_flag        = 1'b1;
    end

    if (!active) begin
      r_next.st       = i2c_slave_pkg::ST_IDLE;
      r_next.sda_oe_n = 1'b1;
      r_next.scl_oe_n = 1'b1;
      r_next.to_run   = 1'b0;
      r_next.bitcnt   = 4'h0;
      r_next.in_addr  = 1'b0;
      r_next.shift    = 8'h00;
    end else if (start) begin
      r_next.status.bus_busy_flag      = 1'b1;
      r_next.status.byte_done_flag     = 1'b0;
      r_next.status.address_match_flag = 1'b0;
      r_next.st       = i2c_slave_pkg::ST_ADDR;
      r_next.bitcnt   = 4'h0;
      r_next.in_addr  = 1'b0;
      r_next.sda_oe_n = 1'b1;
      r_next.scl_oe_n = 1'b1;
      r_next.to_run   = 1'b0;
    end else if (stop) begin
      r_next.status.bus_busy_flag  = 1'b0;
      r_next.status.byte_done_flag = 1'b1;
      r_next.st       = i2c_slave_pkg::ST_IDLE;
      r_next.sda_oe_n = 1'b1;
      r_next.scl_oe_n = 1'b1;
      r_next.bitcnt   = 4'h0;
      r_next.in_addr  = 1'b0;
      r_next.to_run   = 1'b0;
    end else begin
      unique case (r_reg.st)
        i2c_slave_pkg::ST_ADDR: begin
          if (scl_rise) begin
            r_next.shift  = shin;
            r_next.bitcnt = r_reg.bitcnt + 4'h1;
            if (r_reg.bitcnt == `BIT_ADDR_LAST) begin
              // bit 0 of own address ignored
              if (shin[7:1] == r_reg.own_addr[7:1]) begin
                r_next.status.address_match_flag = 1'b1;
                r_next.status.master_read_flag   = shin[0];
                event_hit      = 1'b1;
                r_next.wake    = r_reg.status.addr_match_wakeup_en;
                r_next.in_addr = 1'b1;
                r_next.to_run  = 1'b1;
                r_next.st      = i2c_slave_pkg::ST_ACK;
              end else begin
                r_next.st = i2c_slave_pkg::ST_IDLE;
              end
            end
          end
        end
        i2c_slave_pkg::ST_ACK: begin
          if (scl_fall && r_reg.bitcnt == `BIT_ACK_DRIVE) begin
            if (r_reg.in_addr) begin
              r_next.sda_oe_n = 1'b0;
            end else begin
              r_next.sda_oe_n =
                r_reg.status.transmit_direction_select |
                r_reg.status.tx_ack_value;
            end
          end
          if (scl_rise) begin
            r_next.bitcnt = `BIT_ACK_DONE;
            if (!r_reg.in_addr &&
                r_reg.status.transmit_direction_select) begin
              r_next.status.rx_ack_flag = sda_s;
            end
          end
          if (scl_fall && r_reg.bitcnt == `BIT_ACK_DONE) begin
            r_next.sda_oe_n = 1'b1;
            if (!r_reg.in_addr &&
                r_reg.status.transmit_direction_select &&
                r_reg.status.rx_ack_flag) begin
              // no ack, leave SDA for STOP
              r_next.st = i2c_slave_pkg::ST_WAIT;
            end else begin
              r_next.scl_oe_n = 1'b0;
              r_next.st       = i2c_slave_pkg::ST_HOLD;
            end
          end
        end
        i2c_slave_pkg::ST_HOLD: begin
          if (r_reg.status.transmit_direction_select && data_wr) begin
            r_next.shift    = hwdata[7:0];
            r_next.sda_oe_n = hwdata[7];
            r_next.scl_oe_n = 1'b1;
            r_next.bitcnt   = 4'h0;
            r_next.in_addr  = 1'b0;
            r_next.status.byte_done_flag = 1'b0;
            r_next.st       = i2c_slave_pkg::ST_DATA;
          end else if (!r_reg.status.transmit_direction_select &&
                       data_rd) begin
            r_next.scl_oe_n = 1'b1;
            r_next.bitcnt   = 4'h0;
            r_next.in_addr  = 1'b0;
            r_next.status.byte_done_flag = 1'b0;
            r_next.st       = i2c_slave_pkg::ST_DATA;
          end
        end
        i2c_slave_pkg::ST_DATA: begin
          if (scl_rise) begin
            r_next.bitcnt = r_reg.bitcnt + 4'h1;
            if (!r_reg.status.transmit_direction_select) begin
              r_next.shift = shin;
            end
            if (r_reg.bitcnt == `BIT_ADDR_LAST) begin
              r_next.status.byte_done_flag = 1'b1;
              event_hit = 1'b1;
              if (!r_reg.status.transmit_direction_select) begin
                r_next.data = shin;
              end
              r_next.st = i2c_slave_pkg::ST_ACK;
            end
          end
          if (scl_fall && r_reg.status.transmit_direction_select) begin
            r_next.shift    = {r_reg.shift[6:0], 1'b0};
            r_next.sda_oe_n = r_reg.shift[6];
          end
        end
        i2c_slave_pkg::ST_WAIT: r_next.sda_oe_n = 1'b1;
        default: ;
      endcase
    end

    if (expire) begin
      r_next.toc.timeout_enable = 1'b0;
      r_next.toc.timeout_flag   = 1'b1;
      event_hit = 1'b1;
      r_next.status   = `BUS_STATUS_RST;
      r_next.st       = i2c_slave_pkg::ST_IDLE;
      r_next.bitcnt   = 4'h0;
      r_next.in_addr  = 1'b0;
      r_next.shift    = 8'h00;
      r_next.sda_oe_n = 1'b1;
      r_next.scl_oe_n = 1'b1;
      r_next.to_run   = 1'b0;
    end

    r_next.irq = event_hit & r_reg.irq_en;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r_reg <= CORE_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  assign hrdata    = r_reg.rdata;
  assign hreadyout = r_reg.rdy;
  assign hresp     = r_reg.lo;
  assign scl_o     = r_reg.lo;
  assign sda_o     = r_reg.lo;
  assign scl_oe_n  = r_reg.scl_oe_n;
  assign sda_oe_n  = r_reg.sda_oe_n;
  assign irq       = r_reg.irq;
  assign wake      = r_reg.wake;
endmodule // i2c_slave_with_timeout

/* File: verification/i2c_master_model.sv */
`timescale 1ns/100ps
module i2c_master_model (
  input  wire logic scl,
  input  wire logic sda,
  output logic      scl_m,
  output logic      sda_m
);
  localparam int Q = 50;
  int stalls;
  initial begin
    scl_m = 1'b1;
    sda_m = 1'b1;
    stalls = 0;
  end
  // Waits out clock stretching, bounded so a stuck slave is counted
  task automatic bit_x(input logic b, output logic r);
    int n;
    sda_m = b;
    #Q scl_m = 1'b1;
    n = 0;
    while (scl !== 1'b1 && n < 4000) begin
      #10 n++;
    end
    if (n >= 4000) stalls++;
    #Q r = sda;
    scl_m = 1'b0;
    #Q;
  endtask
  task automatic start();
    sda_m = 1'b1;
    #Q scl_m = 1'b1;
    #Q sda_m = 1'b0;
    #Q scl_m = 1'b0;
    #Q;
  endtask
  task automatic stop();
    sda_m = 1'b0;
    #Q scl_m = 1'b1;
    #Q sda_m = 1'b1;
    #Q;
  endtask
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(d[i], r);
    bit_x(1'b1, ack);
  endtask
  task automatic rd_byte(input logic ak, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, r);
      d[i] = r;
    end
    bit_x(ak, r);
  endtask
endmodule // i2c_master_model

/* File: verification/i2c_slave_with_timeout_asserts.sv */
`timescale 1ns/100ps
module i2c_slave_with_timeout_asserts (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        scl_i,
  input wire logic        scl_o,
  input wire logic        scl_oe_n,
  input wire logic        sda_o,
  input wire logic        sda_oe_n,
  input wire logic        irq,
  input wire logic        wake
);
  logic acc_reg;
  logic acc_next;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Data register access seen since the stretch began
  assign acc_next = (hsel & htrans[1] & hready & (haddr[7:0] == 8'h0C))
                  | (acc_reg & ~scl_oe_n);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) acc_reg <= 1'b0;
    else acc_reg <= acc_next;
  end
  sequence ack_drive;
    ##[1:80] !sda_oe_n;
  endsequence
  sequence ack_end_hold;
    ##[1:120] (sda_oe_n && !scl_oe_n);
  endsequence
  a_open_drain: assert property (!scl_o && !sda_o)
    else $error("open drain pin driven high");
  a_no_start: assert property ($fell(sda_oe_n) |-> !$past(scl_i))
    else $error("sda pulled low while scl high");
  a_no_stop: assert property ($rose(sda_oe_n) |-> !$past(scl_i))
    else $error("sda released while scl high");
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not ready and okay");
  a_irq_pulse: assert property (irq |=> !irq)
    else $error("interrupt longer than one cycle");
  a_wake_pulse: assert property (wake |=> !wake)
    else $error("wake longer than one cycle");
  a_match_seq: assert property (wake |-> ack_drive ##0 ack_end_hold)
    else $error("no acknowledge then stretch after match");
  // Timeout also frees the clock, signalled by its interrupt
  a_stretch_rel: assert property ($rose(scl_oe_n) |->
    (acc_reg || irq || $past(irq) || $past(irq, 2)))
    else $error("stretch released without data access");
endmodule // i2c_slave_with_timeout_asserts
bind i2c_slave_with_timeout i2c_slave_with_timeout_asserts u_chk (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .scl_i(scl_i), .scl_o(scl_o), .scl_oe_n(scl_oe_n), .sda_o(sda_o),
  .sda_oe_n(sda_oe_n), .irq(irq), .wake(wake));

/* File: verification/tb_i2c_slave_with_timeout.sv */
`timescale 1ns/100ps
module tb_i2c_slave_with_timeout;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        scl_o, scl_oe_n, sda_o, sda_oe_n, sub_clk, irq, wake;
  logic        scl_m, sda_m, ak, dir;
  wire         scl, sda;
  logic [6:0]  own;
  logic [7:0]  d, b;
  int          bad_count, samples_checked, irq_cnt, wake_cnt, i0, n, sel;
  logic [7:0]  ofs [7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18};
  logic [7:0]  por [7] = '{8'hE0, 8'h81, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  // Pull-ups: a line is low when either party pulls it
  assign scl = scl_m & scl_oe_n;
  assign sda = sda_m & sda_oe_n;
  i2c_slave_with_timeout dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .scl_i(scl), .scl_o(scl_o),
    .scl_oe_n(scl_oe_n), .sda_i(sda), .sda_o(sda_o), .sda_oe_n(sda_oe_n),
    .sub_clk(sub_clk), .irq(irq), .wake(wake));
  i2c_master_model m (.scl(scl), .sda(sda), .scl_m(scl_m), .sda_m(sda_m));
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  initial begin
    sub_clk = 1'b0;
    #7;
    forever #20 sub_clk = ~sub_clk;
  end
  always @(posedge hclk) begin
    if (irq === 1'b1) irq_cnt++;
    if (wake === 1'b1) wake_cnt++;
  end
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] s, e);
    samples_checked++;
    if (s !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %0h seen %0h", nm, e, s);
    end
  endtask
  // Expected time-out in hclk cycles; sub_clk period is four hclk
  function automatic int to_cycles(input int s);
    return (s + 1) * 32 * 4;
  endfunction
  task automatic ahb(input logic w, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] r);
    int k;
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while (hreadyout !== 1'b1 && k < 20);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do begin
      @(posedge hclk);
      k++;
    end while (hreadyout !== 1'b1 && k < 40);
    r = hrdata;
    if (k >= 40) begin
      bad_count++;
      print_verdict();
    end
  endtask
  task automatic wr(input logic [7:0] a, v);
    ahb(1'b1, a, {24'h0, v}, rd);
  endtask
  task automatic rc(input string nm, input logic [7:0] a, mk, e);
    ahb(1'b0, a, 32'h0, rd);
    chk(nm, rd & {24'h0, mk}, {24'h0, e});
  endtask
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    bad_count = 0;
    samples_checked = 0;
    irq_cnt = 0;
    wake_cnt = 0;
    void'($urandom(32'hE69A8108));
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    for (int i = 0; i < 7; i++) rc("por", ofs[i], 8'hFF, por[i]);
    $display("reset test done");
    own = 7'($urandom);
    wr(8'h00, 8'hC2);
    wr(8'h08, {own, 1'b1});
    wr(8'h14, 8'h01);
    wr(8'h04, 8'h02);
    i0 = irq_cnt;
    m.start();
    m.wr_byte({own ^ 7'(1 << $urandom_range(6)), 1'b0}, ak);
    chk("foreign addr ack", ak, 1'b1);
    m.stop();
    chk("foreign irq", irq_cnt - i0, 0);
    for (int t = 0; t < 4; t++) begin
      dir = t[0];
      i0 = irq_cnt;
      m.start();
      m.wr_byte({own, dir}, ak);
      chk("addr ack", ak, 1'b0);
      rc("match", 8'h04, 8'h64, {5'b01100, dir, 2'b00});
      chk("match irq", irq_cnt - i0, 1);
      chk("wake", wake_cnt, t + 1);
      chk("stretch", scl_oe_n, 1'b0);
      // firmware sets direction from read flag
      wr(8'h04, dir ? 8'h12 : 8'h02);
      if (!dir) ahb(1'b0, 8'h0C, 32'h0, rd);
      for (int k = 0; k < 2; k++) begin
        d = 8'($urandom);
        if (dir) begin
          wr(8'h0C, d);
          m.rd_byte(k[0], b);
          chk("tx byte", b, d);
          rc("rx ack", 8'h04, 8'h81, {1'b1, 6'h0, k[0]});
        end else begin
          if (k == 1) wr(8'h04, 8'h0A);
          m.wr_byte(d, ak);
          chk("ack sent", ak, k[0]);
          rc("done", 8'h04, 8'h80, 8'h80);
          rc("rx byte", 8'h0C, 8'hFF, d);
        end
        chk("byte irq", irq_cnt - i0, k + 2);
      end
      if (dir) chk("sda free", sda_oe_n, 1'b1);
      m.stop();
      rc("idle", 8'h04, 8'hA0, 8'h80);
    end
    $display("transfer test done");
    sel = 1 + $urandom_range(1);
    wr(8'h10, 8'h80 | 8'(sel));
    m.start();
    m.wr_byte({own, 1'b0}, ak);
    wr(8'h04, 8'h02);
    ahb(1'b0, 8'h0C, 32'h0, rd);
    d = 8'($urandom);
    m.wr_byte(d, ak);
    rc("no timeout", 8'h10, 8'hFF, 8'h80 | 8'(sel));
    i0 = irq_cnt;
    n = 0;
    while (irq_cnt == i0 && n < 2000) begin
      @(posedge hclk);
      n++;
    end
    n = n - to_cycles(sel);
    chk("period", n > -40 && n <= 10, 1);
    rc("to flag", 8'h10, 8'hFF, 8'h40 | 8'(sel));
    rc("status por", 8'h04, 8'hFF, 8'h81);
    rc("data kept", 8'h0C, 8'hFF, d);
    rc("addr kept", 8'h08, 8'hFF, {own, 1'b1});
    rc("mode kept", 8'h00, 8'hFF, 8'hC2);
    chk("scl free", scl_oe_n, 1'b1);
    wr(8'h10, 8'h00);
    rc("flag clear", 8'h10, 8'hFF, 8'h00);
    m.stop();
    // any other mode leaves the engine idle
    wr(8'h00, 8'hE2);
    m.start();
    m.wr_byte({own, 1'b0}, ak);
    chk("off mode ack", ak, 1'b1);
    rc("off mode busy", 8'h04, 8'h20, 8'h00);
    m.stop();
    chk("stalls", m.stalls, 0);
    $display("timeout test done");
    print_verdict();
  end
endmodule // tb_i2c_slave_with_timeout
